// ### shared/sbcff_pkg.sv
// Constants and carrier types of the fault flag and status reporter
package sbcff_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 200; // Core clock, MHz
  localparam int FILT_US = 100; // Fault filter time, us
  localparam int FILT_W = 15; // Filter counter width
  // Filter time in core cycles
  localparam logic [FILT_W-1:0] FILT_CYC_D = FILT_W'(FILT_US * CLK_MHZ);
  localparam int RSTP_MS = 100; // Short reset pulse limit, ms
  localparam int RSTP_W = 25; // Reset low timer width
  // Short reset pulse limit in core cycles
  localparam logic [RSTP_W-1:0] RSTP_CYC_D = RSTP_W'(RSTP_MS * 1000 * CLK_MHZ);

  // ****************************************
  // Frame and command fields
  // ****************************************
  localparam logic [4:0] CNT_HDR = 5'h08; // Command byte complete
  localparam logic [4:0] CNT_PAGE = 5'h09; // Page bit complete
  localparam logic [4:0] CNT_FRAME = 5'h10; // Whole frame
  localparam logic [1:0] KIND_FLAG = 2'h3; // Flag read kind
  localparam logic [1:0] KIND_STAT = 2'h0; // Status read kind
  localparam logic [4:0] ADDR_REG = 5'h0f; // Regulator flags
  localparam logic [4:0] ADDR_ID = 5'h12; // Int, reset flags and identification
  localparam logic [4:0] ADDR_LIN1 = 5'h13; // LIN channel one
  localparam logic [4:0] ADDR_LIN2 = 5'h14; // LIN channel two
  localparam logic [15:0] CMD_LIN2_FLAGS = 16'he900; // LIN two flag read
  localparam logic [15:0] CMD_LIN1_STAT = 16'h2780; // LIN one status read
  localparam logic [15:0] CMD_LIN2_STAT = 16'h2980; // LIN two status read
  localparam logic [4:0] ID_CODE = 5'h0a; // Identification code, arbitrary value
  localparam logic [15:0] SY_IDLE = 16'h5000; // Pin sync stages at idle: chip select and reset pin high

  // ****************************************
  // Flag vector layout
  // ****************************************
  localparam int FL_W = 30; // Flag vector width; bits 11 and 13 to 15 are never set
  localparam int LIN_FW = 7; // Flags per LIN channel
  localparam int FB_OC_NORM = 0; // Core overcurrent, normal mode
  localparam int FB_MAIN_UV = 1; // Main supply undervoltage
  localparam int FB_SENSE = 2; // Sense input low
  localparam int FB_CAN_OC = 3; // CAN supply overcurrent
  localparam int FB_CAN_UV = 4; // CAN supply undervoltage
  localparam int FB_CAN_OT = 5; // CAN supply thermal
  localparam int FB_AUX_OC = 6; // Aux regulator overcurrent
  localparam int FB_AUX_LOW = 7; // Aux regulator low
  localparam int FB_OC_LP = 8; // Core overcurrent, low power
  localparam int FB_BATFAIL = 9; // Battery fail
  localparam int FB_SHORT_RST = 10; // Short reset pulse
  localparam int FB_CORE_OT = 12; // Core regulator thermal
  localparam int FB_LIN1 = 16; // LIN one flags base
  localparam int FB_LIN2 = 23; // LIN two flags base

  // ****************************************
  // Types
  // ****************************************
  // Decoded command, one-hot
  typedef enum logic [7:0] {
    CMD_NONE = 8'h01,
    CMD_REG0 = 8'h02,
    CMD_REG1 = 8'h04,
    CMD_LIN1F = 8'h08,
    CMD_LIN2F = 8'h10,
    CMD_LIN1S = 8'h20,
    CMD_LIN2S = 8'h40,
    CMD_ID = 8'h80
  } sbcff_cmd_t;

  // Detector levels, asynchronous to the core clock
  typedef struct packed {
    logic aux_uv; // Aux output under threshold
    logic aux_oc; // Aux current over limit
    logic can_ot; // CAN supply sensor hot
    logic can_uv; // CAN supply under threshold
    logic can_oc; // CAN supply current over limit
    logic sense_low; // Sense input under threshold
    logic main_uv; // Primary supply under threshold
    logic core_oc; // Core regulator current over limit
    logic core_ot_off; // Core regulator off for heat
    logic batfail; // Primary supply under battery-fail level
    logic normal_mode; // Device in normal mode
    logic lp_vdd_on; // Device in low power, core on
  } sbcff_det_t;

  // LIN fault levels and states, core clock domain
  typedef struct packed {
    logic [LIN_FW-1:0] l1_flt; // Channel one fault levels
    logic [LIN_FW-1:0] l2_flt; // Channel two fault levels
    logic l1_state; // Channel one state
    logic l1_wu_en; // Channel one wake-up enable
    logic l2_state; // Channel two state
    logic l2_wu_en; // Channel two wake-up enable
  } sbcff_lin_t;

endpackage : sbcff_pkg

// ### src/sbcff_filter.sv
// Fault condition filter: a level counts only after standing a set time
`timescale 1ns/1ps
module sbcff_filter #(
  parameter logic [sbcff_pkg::FILT_W-1:0] LIMIT = sbcff_pkg::FILT_CYC_D // Cycles to stand
) (
  input wire logic core_clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic raw_i, // Condition, core domain
  output logic filt_o // Filtered condition
);
  import sbcff_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [FILT_W-1:0] cnt; // Time the level has stood
    logic filt; // Filtered level
  } sbcff_filt_st_t;

  sbcff_filt_st_t q; // Registered state
  sbcff_filt_st_t d; // Next state

  // Count while the condition stands, drop at once when it goes
  always_comb begin
    d = q;
    if (!raw_i) begin
      d.cnt = '0;
      d.filt = 1'b0;
    end else if (q.cnt == LIMIT) begin
      d.filt = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign filt_o = q.filt;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb_filt @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_filt_time: assert property (
    $rose(q.filt) |-> ($past(q.cnt) == LIMIT) && $past(raw_i))
    else $error("filter fired before its full time");

endmodule : sbcff_filter

// ### src/sbcff_core.sv
// Fault flag and LIN status reporter behind a 16-bit SPI command slave
`timescale 1ns/1ps
//
// Summary of operation
// - Aux low flag after 100 us filter
// - Aux overcurrent: filtered set, clear on read
// - CAN supply thermal flag, clear on read
// - CAN supply undervoltage: filtered, clear on read
// - CAN supply overcurrent: filtered, clear on read
// - Sense input low: filtered, clear on read
// - Main supply undervoltage: filtered, clear on read
// - Core overcurrent in normal mode, filtered
// - Core regulator thermal off flag, clear on read
// - Reset pin pulse under 100 ms flagged
// - Battery fail flag, clear on read
// - Core overcurrent in low power, filtered
// - Command 0xe900 returns LIN two flags
// - Command 0x2780 returns LIN one status
// - Command 0x2980 returns LIN two status
//
module sbcff_core #(
  parameter logic [sbcff_pkg::FILT_W-1:0] FILT_CYC = sbcff_pkg::FILT_CYC_D, // Filter time
  parameter logic [sbcff_pkg::RSTP_W-1:0] RSTP_CYC = sbcff_pkg::RSTP_CYC_D // Short pulse limit
) (
  input wire logic core_clk_i, // Core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic spi_sclk_i, // Serial clock pin
  input wire logic spi_cs_n_i, // Chip select pin, active low
  input wire logic spi_mosi_i, // Serial data in pin
  output logic spi_miso_o, // Serial data out pin
  input wire logic rst_pin_i, // Reset pin level
  input wire sbcff_pkg::sbcff_det_t det_i, // Detector levels
  input wire sbcff_pkg::sbcff_lin_t lin_i, // LIN levels and states
  input wire logic [7:0] fixed_status_i, // Answer high byte
  input wire logic vdd_sel_i, // Core regulator voltage option
  input wire logic [1:0] part_num_i, // Part number bits
  output logic [sbcff_pkg::FL_W-1:0] flags_o // Latched flags
);
  import sbcff_pkg::*;

  // ****************************************
  // State
  // ****************************************
  localparam int PIN_W = 4 + $bits(sbcff_det_t); // Pins passing the synchroniser

  typedef struct packed {
    logic [PIN_W-1:0] sy1; // First sync stage
    logic [PIN_W-1:0] sy2; // Second sync stage
    logic sck_p; // Serial clock, last cycle
    logic cs_p; // Chip select, last cycle
    logic rst_p; // Reset pin, last cycle
    logic [4:0] rx_cnt; // Bits received
    logic [4:0] tx_cnt; // Bits shifted out
    logic [15:0] rx; // Received command
    logic [7:0] hi; // Answer high byte
    logic [7:0] lo; // Answer low byte as shown
    logic [7:0] rep; // Byte taken as read
    sbcff_cmd_t cmd; // Decoded command
    logic miso; // Serial out
    logic [FL_W-1:0] flag; // Latched flags
    logic [FL_W-1:0] seen; // Read while condition held
    logic [RSTP_W-1:0] rcnt; // Reset pin low time
  } sbcff_core_st_t;

  sbcff_core_st_t q; // Registered state
  sbcff_core_st_t d; // Next state

  // Reset value: pins seen as idle, so no false edge follows reset
  localparam sbcff_core_st_t ST_RST = '{sy1: SY_IDLE, sy2: SY_IDLE, cs_p: 1'b1, rst_p: 1'b1,
    cmd: CMD_NONE, default: '0};

  // ****************************************
  // Synchronised pins
  // ****************************************
  logic s_sck; // Serial clock
  logic s_cs_n; // Chip select, active low
  logic s_mosi; // Serial data in
  logic s_rst; // Reset pin
  sbcff_det_t s_det; // Detector levels

  assign {s_sck, s_cs_n, s_mosi, s_rst, s_det} = q.sy2;

  // ****************************************
  // Decoding
  // ****************************************
  // Command byte plus page bit to command
  function automatic sbcff_cmd_t cmd_dec(input logic [7:0] b, input logic pg);
    sbcff_cmd_t c;
    c = CMD_NONE;
    if (b[0] && b[7:6] == KIND_FLAG) begin
      // Latched flag reads
      case (b[5:1])
        ADDR_REG: c = pg ? CMD_REG1 : CMD_REG0;
        ADDR_LIN1: c = pg ? CMD_NONE : CMD_LIN1F;
        ADDR_LIN2: c = pg ? CMD_NONE : CMD_LIN2F;
        default: c = CMD_NONE;
      endcase
    end else if (b[0] && pg && b[7:6] == KIND_STAT) begin
      // Real time status reads
      case (b[5:1])
        ADDR_ID: c = CMD_ID;
        ADDR_LIN1: c = CMD_LIN1S;
        ADDR_LIN2: c = CMD_LIN2S;
        default: c = CMD_NONE;
      endcase
    end
    return c;
  endfunction : cmd_dec

  // Command to answer byte
  function automatic logic [7:0] ans_sel(input sbcff_cmd_t c, input logic [FL_W-1:0] f,
      input sbcff_lin_t l, input logic [7:0] idb);
    logic [7:0] a;
    a = 8'h00;
    case (c)
      CMD_REG0: a = f[7:0];
      CMD_REG1: a = f[15:8];
      CMD_LIN1F: a = {1'b0, f[FB_LIN1 +: LIN_FW]};
      CMD_LIN2F: a = {1'b0, f[FB_LIN2 +: LIN_FW]};
      CMD_LIN1S: a = {l.l1_state, l.l1_wu_en, 6'h00};
      CMD_LIN2S: a = {l.l2_state, l.l2_wu_en, 6'h00};
      CMD_ID: a = idb;
      default: a = 8'h00;
    endcase
    return a;
  endfunction : ans_sel

  // ****************************************
  // Fault filters
  // ****************************************
  logic [7:0] f_raw; // Conditions before filtering
  logic [7:0] f_out; // Filtered conditions

  // Overcurrent of the core regulator is split by mode
  assign f_raw = {s_det.aux_uv, s_det.aux_oc, s_det.core_oc & s_det.lp_vdd_on, s_det.can_uv,
    s_det.can_oc, s_det.sense_low, s_det.main_uv, s_det.core_oc & s_det.normal_mode};

  for (genvar g = 0; g < 8; g++) begin : g_filt
    sbcff_filter #(
      .LIMIT(FILT_CYC)
    ) u_filt (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .raw_i(f_raw[g]),
      .filt_o(f_out[g])
    );
  end

  // ****************************************
  // Flag causes
  // ****************************************
  logic rst_short; // Reset pin pulse just ended short
  logic [FL_W-1:0] set_v; // Set causes
  logic [FL_W-1:0] hold_v; // Conditions still present
  logic [15:0] rx_new; // Command with the new bit
  logic sck_rise; // Serial clock rising
  logic sck_fall; // Serial clock falling
  logic [7:0] id_byte; // Identification answer
  logic [7:0] sel; // Answer byte being chosen
  logic [4:0] tx_new; // Next out bit count
  logic [FL_W-1:0] rd_now; // Flags read in ending frame
  logic [FL_W-1:0] clr_v; // Flags allowed to clear
  logic [15:0] ans_w; // Whole answer word, high byte first

  // Release of the reset pin before the limit
  assign rst_short = s_rst && !q.rst_p && (q.rcnt != RSTP_CYC);
  assign rx_new = {q.rx[14:0], s_mosi};
  assign sck_rise = s_sck && !q.sck_p;
  assign sck_fall = !s_sck && q.sck_p;
  assign id_byte = {vdd_sel_i, part_num_i, ID_CODE};
  assign tx_new = q.tx_cnt + 5'h01;
  assign ans_w = {q.hi, q.lo};

  // What sets each flag and what keeps it from clearing
  always_comb begin
    set_v = '0;
    set_v[FB_AUX_LOW] = f_out[7];
    set_v[FB_AUX_OC] = f_out[6];
    set_v[FB_CAN_OT] = s_det.can_ot;
    set_v[FB_CAN_UV] = f_out[4];
    set_v[FB_CAN_OC] = f_out[3];
    set_v[FB_SENSE] = f_out[2];
    set_v[FB_MAIN_UV] = f_out[1];
    set_v[FB_OC_NORM] = f_out[0];
    set_v[FB_CORE_OT] = s_det.core_ot_off;
    set_v[FB_SHORT_RST] = rst_short;
    set_v[FB_BATFAIL] = s_det.batfail;
    set_v[FB_OC_LP] = f_out[5];
    set_v[FB_LIN1 +: LIN_FW] = lin_i.l1_flt;
    set_v[FB_LIN2 +: LIN_FW] = lin_i.l2_flt;
    hold_v = set_v;
    // Pulse flag holds while the pin is still low
    hold_v[FB_SHORT_RST] = !s_rst;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    sel = 8'h00;
    rd_now = '0;
    // Two flip-flop synchroniser
    d.sy1 = {spi_sclk_i, spi_cs_n_i, spi_mosi_i, rst_pin_i, det_i};
    d.sy2 = q.sy1;
    d.sck_p = s_sck;
    d.cs_p = s_cs_n;
    d.rst_p = s_rst;

    // Reset pin low timer, saturating at the limit
    if (!s_rst) begin
      if (q.rcnt != RSTP_CYC) begin
        d.rcnt = q.rcnt + 1'b1;
      end
    end else begin
      d.rcnt = '0;
    end

    // Frame end: bits set in the byte taken as read in a clean full flag read count as read
    if (s_cs_n && !q.cs_p) begin
      if (q.rx_cnt == CNT_FRAME && q.rx[6:0] == 7'h00) begin
        case (q.cmd)
          CMD_REG0: rd_now[7:0] = q.rep;
          CMD_REG1: rd_now[15:8] = q.rep;
          CMD_LIN1F: rd_now[FB_LIN1 +: LIN_FW] = q.rep[6:0];
          CMD_LIN2F: rd_now[FB_LIN2 +: LIN_FW] = q.rep[6:0];
          default: rd_now = '0;
        endcase
      end
    end

    if (s_cs_n) begin
      // Idle between frames
      d.miso = 1'b0;
    end else if (q.cs_p) begin
      // Frame start: high byte goes out first
      d.rx_cnt = '0;
      d.tx_cnt = '0;
      d.hi = fixed_status_i;
      d.lo = 8'h00;
      d.rep = 8'h00;
      d.cmd = CMD_NONE;
      d.miso = fixed_status_i[7];
    end else if (sck_rise) begin
      // Shift a command bit in
      d.rx = rx_new;
      if (q.rx_cnt != 5'h1f) begin
        d.rx_cnt = q.rx_cnt + 5'h01;
      end
      if (d.rx_cnt == CNT_HDR) begin
        // Page not known yet: status kinds assume the status page
        d.cmd = cmd_dec(rx_new[7:0], rx_new[7:6] == KIND_STAT);
        sel = ans_sel(d.cmd, q.flag, lin_i, id_byte);
        d.lo = sel;
      end else if (d.rx_cnt == CNT_PAGE) begin
        // Page known: settle the remaining seven bits
        d.cmd = cmd_dec(rx_new[8:1], rx_new[0]);
        sel = ans_sel(d.cmd, q.flag, lin_i, id_byte);
        d.lo = {q.lo[7], sel[6:0]};
        d.rep = sel;
      end
    end else if (sck_fall && q.tx_cnt < 5'h0f) begin
      // Shift the answer out, high byte then low byte
      d.tx_cnt = tx_new;
      d.miso = ans_w[4'hf - tx_new[3:0]];
    end

    // Flags: set wins, clear needs a read and the condition gone
    clr_v = (q.seen | rd_now) & ~hold_v;
    d.flag = set_v | (q.flag & ~clr_v);
    d.seen = d.flag & (q.seen | rd_now) & ~(set_v & ~hold_v);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign spi_miso_o = q.miso;
  assign flags_o = q.flag;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb_core @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Ninth command bit taken inside a frame
  sequence s_cmd9(logic [8:0] w);
    sck_rise && !s_cs_n && !q.cs_p && q.rx_cnt == CNT_HDR && rx_new[8:0] == w;
  endsequence

  // Eighth falling edge inside a frame
  sequence s_fall8;
    sck_fall && !s_cs_n && !q.cs_p && q.tx_cnt == 5'h07;
  endsequence

  a_lin2_flags: assert property (
    s_cmd9(CMD_LIN2_FLAGS[15:7]) |=> q.rep == {1'b0, $past(q.flag[FB_LIN2 +: LIN_FW])})
    else $error("LIN two flag read gave wrong byte");

  a_lin1_status: assert property (
    s_cmd9(CMD_LIN1_STAT[15:7]) |=> q.rep == {$past(lin_i.l1_state), $past(lin_i.l1_wu_en), 6'h00})
    else $error("LIN one status read gave wrong byte");

  a_lin2_status: assert property (
    s_cmd9(CMD_LIN2_STAT[15:7]) |=> q.rep[7:6] == {$past(lin_i.l2_state), $past(lin_i.l2_wu_en)})
    else $error("LIN two status read gave wrong byte");

  a_miso_low: assert property (
    s_fall8 |=> q.miso == $past(q.lo[7]) && q.tx_cnt == 5'h08)
    else $error("answer low byte not on serial out");

  a_can_ot_set: assert property (
    s_det.can_ot |=> q.flag[FB_CAN_OT])
    else $error("thermal flag not held with hot sensor");

  a_hold_keep: assert property (
    q.flag[FB_AUX_OC] && f_out[6] |=> q.flag[FB_AUX_OC])
    else $error("overcurrent flag cleared while present");

  a_clear_read: assert property (
    $fell(q.flag[FB_SENSE]) |-> $past(q.seen[FB_SENSE] || rd_now[FB_SENSE]) && !$past(f_out[2]))
    else $error("sense flag cleared without read or recovery");

  a_norm_gate: assert property (
    $rose(q.flag[FB_OC_NORM]) |-> $past(s_det.normal_mode, 2))
    else $error("normal mode overcurrent set outside normal mode");

  a_short_rst: assert property (
    s_rst && !q.rst_p && q.rcnt < RSTP_CYC |=> q.flag[FB_SHORT_RST])
    else $error("short reset pulse not flagged");

endmodule : sbcff_core

// ### tb/sbcff_host_model.sv
// Host side serial master model sending 16-bit command frames
`timescale 1ns/1ps
module sbcff_host_model (
  input wire logic core_clk_i, // Core clock
  output logic sclk_o, // Serial clock, idle low
  output logic cs_n_o, // Chip select, active low
  output logic mosi_o, // Serial data to device
  input wire logic miso_i // Serial data from device
);
  // Idle levels at time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ****************************************
  // Frame transfer
  // ****************************************
  // Sends nb bits MSB first, each clock level held 5 core cycles
  task automatic xfer(input logic [15:0] cmd, input int nb, output logic [15:0] rsp);
    rsp = 16'h0000;
    @(posedge core_clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      sclk_o <= 1'b0;
      mosi_o <= cmd[15-i]; // Data changes with the falling clock
      repeat (5) @(posedge core_clk_i);
      sclk_o <= 1'b1;
      rsp[15-i] = miso_i; // Answer taken at the rising clock
      repeat (5) @(posedge core_clk_i);
    end
    sclk_o <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // Released line shows no stale bit
    repeat (6) @(posedge core_clk_i);
  endtask : xfer
endmodule : sbcff_host_model

// ### tb/tb_top.sv
// Self-checking bench of the fault flag and status reporter
`timescale 1ns/1ps
module tb_top;
  import sbcff_pkg::*;
  // ****************************************
  // Settings and signals
  // ****************************************
  localparam logic [FILT_W-1:0] FCYC = 15'h0014; // Shortened filter time
  localparam logic [RSTP_W-1:0] RCYC = 25'h00000c8; // Shortened reset pulse limit
  localparam int DB [11] = '{11, 10, 9, 8, 7, 6, 5, 4, 4, 3, 2}; // Detector bit per case
  localparam int FB [11] = '{7, 6, 5, 4, 3, 2, 1, 0, 8, 12, 9}; // Flag bit per case
  localparam bit FLT [11] = '{1, 1, 0, 1, 1, 1, 1, 1, 1, 0, 0}; // Case is filtered
  localparam logic [15:0] BAD [4] = '{16'he100, 16'he980, 16'h2700, 16'h0000}; // Refused commands
  logic clk, arst_n, sclk, cs_n, mosi, miso, rst_pin, vdd_sel;
  logic [1:0] part_num; // Part number bits
  logic [7:0] fixed; // Answer high byte
  sbcff_det_t det; // Detector levels
  sbcff_lin_t lin; // LIN levels
  logic [FL_W-1:0] flags, exp_fl; // Seen and expected flags
  logic [31:0] seed = 32'h33523448; // Random state
  int n_errors = 0;
  int checks_done = 0;

  // Design and host model
  sbcff_core #(.FILT_CYC(FCYC), .RSTP_CYC(RCYC)) sbcff_core_inst (.core_clk_i(clk), .arst_n_i(arst_n),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .rst_pin_i(rst_pin),
    .det_i(det), .lin_i(lin), .fixed_status_i(fixed), .vdd_sel_i(vdd_sel), .part_num_i(part_num),
    .flags_o(flags));
  sbcff_host_model sbcff_host_model_inst (.core_clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso));

  // ****************************************
  // Helpers
  // ****************************************
  // Next random word from the shift register
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h00000000);
    return seed;
  endfunction : rnd

  // Expected flag byte for the page holding bit f
  function automatic logic [7:0] pg_byte(input int f, input logic [FL_W-1:0] fl);
    return (f < 8) ? fl[7:0] : fl[15:8];
  endfunction : pg_byte

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One frame with a random high byte
  task automatic frame(input logic [15:0] cmd, input int nb, output logic [7:0] lo);
    logic [15:0] r;
    logic [7:0] fx;
    fx = rnd() & 32'h000000ff;
    fixed <= fx;
    sbcff_host_model_inst.xfer(cmd, nb, r);
    if (nb == 16) chk("answer high byte", r[15:8], fx);
    lo = r[7:0];
  endtask : frame

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] lo;
    logic [15:0] cmd;
    arst_n = 1'b0;
    rst_pin = 1'b1;
    det = '0;
    lin = '0;
    fixed = 8'h00;
    vdd_sel = 1'b0;
    part_num = 2'h0;
    exp_fl = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("flags after reset", flags, exp_fl);
    // Each detector: short pulse if filtered, long fault, clear order alternating by case
    for (int i = 0; i < 11; i++) begin
      cmd = (FB[i] < 8) ? 16'hdf00 : 16'hdf80;
      det[1:0] <= (i == 7) ? 2'b10 : (i == 8) ? 2'b01 : 2'(rnd());
      if (FLT[i]) begin
        det[DB[i]] <= 1'b1;
        repeat (2 + int'(rnd() % 32'd16)) @(posedge clk);
        det[DB[i]] <= 1'b0;
        repeat (30) @(posedge clk);
        chk("short pulse", flags, exp_fl);
      end
      det[DB[i]] <= 1'b1;
      repeat (FCYC + 12) @(posedge clk);
      exp_fl[FB[i]] = 1'b1;
      chk("flag set", flags, exp_fl);
      if (i % 2 == 1) begin
        frame(cmd, 16, lo);
        chk("flag answer", lo, pg_byte(FB[i], exp_fl));
        chk("held while present", flags, exp_fl);
        det[DB[i]] <= 1'b0;
      end else begin
        det[DB[i]] <= 1'b0;
        repeat (10) @(posedge clk);
        chk("held until read", flags, exp_fl);
        frame(cmd, 8, lo);
        frame(cmd | 16'h0001, 16, lo);
        chk("bad frames clear nothing", flags, exp_fl);
        frame(cmd, 16, lo);
        chk("flag answer", lo, pg_byte(FB[i], exp_fl));
      end
      repeat (10) @(posedge clk);
      exp_fl[FB[i]] = 1'b0;
      chk("flag cleared", flags, exp_fl);
    end
    // Core overcurrent outside both modes
    @(posedge clk);
    det <= sbcff_det_t'(12'h010); // Core overcurrent alone, no mode bit
    repeat (FCYC + 12) @(posedge clk);
    chk("no mode no flag", flags, exp_fl);
    det <= '0;
    // Short and long reset pin pulses
    rst_pin <= 1'b0;
    repeat (10 + int'(rnd() % 32'd150)) @(posedge clk);
    rst_pin <= 1'b1;
    repeat (8) @(posedge clk);
    exp_fl[10] = 1'b1;
    chk("short reset pulse", flags, exp_fl);
    frame(16'hdf80, 16, lo);
    chk("reset flag answer", lo, pg_byte(10, exp_fl));
    exp_fl[10] = 1'b0;
    chk("reset flag cleared", flags, exp_fl);
    @(posedge clk);
    rst_pin <= 1'b0;
    repeat (RCYC + 50) @(posedge clk);
    rst_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk("long reset pulse", flags, exp_fl);
    // LIN flags and real time status
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      lin <= 18'(rnd());
      repeat (4) @(posedge clk);
      exp_fl[29:16] = {lin.l2_flt, lin.l1_flt};
      chk("lin flags", flags, exp_fl);
      frame(CMD_LIN2_FLAGS, 16, lo);
      chk("lin two flag answer", lo, {1'b0, lin.l2_flt});
      frame(CMD_LIN1_STAT, 16, lo);
      chk("lin one status", lo, {lin.l1_state, lin.l1_wu_en, 6'h00});
      frame(CMD_LIN2_STAT, 16, lo);
      chk("lin two status", lo, {lin.l2_state, lin.l2_wu_en, 6'h00});
      lin <= '0;
      repeat (4) @(posedge clk);
      exp_fl[29:23] = '0;
      chk("lin read clears own", flags, exp_fl);
      frame(16'he700, 16, lo);
      chk("lin one flag answer", lo, {1'b0, exp_fl[22:16]});
      exp_fl[22:16] = '0;
      chk("lin one cleared", flags, exp_fl);
    end
    // Identification and refused commands
    vdd_sel <= rnd() % 32'd2;
    part_num <= 2'(rnd());
    lin <= 18'h00005; // Wake-up enables on, so a refused status read can show a wrong byte
    frame(16'h2580, 16, lo);
    chk("identification", lo, {vdd_sel, part_num, ID_CODE});
    foreach (BAD[j]) begin
      frame(BAD[j], 16, lo);
      chk("refused answer", lo, 8'h00);
    end
    // Reset in mid-run drops a raw flag
    det[2] <= 1'b1;
    repeat (6) @(posedge clk);
    exp_fl[9] = 1'b1;
    chk("battery fail before reset", flags, exp_fl);
    det[2] <= 1'b0;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("flags after second reset", flags, '0);
    wrap_up();
  end
endmodule : tb_top
